// ===== rtl/gop_ctrl.sv
// How it works
// - Switch 1 enables or kills auto close
// - Switch 2 on: warning two seconds early
// - Switch 2 off: warning only while running
// - Switch 3 on: open-stop-close-stop single button
// - Switch 3 off: open, or close when open
// - Switch 4 swaps motor and limit mapping
// - Switch 5 on: unlock, wait one second first
// - Brake-disable switch suppresses the motor brake
// - Switch 8 selects slave role
// - Broken stop loop halts, blocks operation
// - Open input drives gate toward open
// - Close input drives gate toward closed
// - Reverse while closing runs fully open
// - Open obstruction: stop, back off, stop
// - First obstruction inhibits auto close, needs command
// - Repeat obstruction before limit: alarm, lockout
// - Close obstruction mirrors open, closing only
// - Hold-open loop refuses closing
// - Auto close after set delay from open
// - Max run timer expiry locks out, alarms
// - Direction limit switch stops the motor
`timescale 1ns/100ps
`default_nettype none
module gop_ctrl
    import gop_pkg::*;
#(
    parameter int TICK_CYCLES = gop_pkg::TICK_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire gop_pkg::gop_in_t ctl_in,
    input  wire logic [7:0]       dip_sw,
    output gop_pkg::gop_out_t     ctl_out
);
    import gop_pkg::*;
    localparam int             DW       = $clog2(TICK_CYCLES + 1);
    localparam logic [DW-1:0]  DIV_LAST = DW'(TICK_CYCLES - 1);
    typedef struct packed {
        gop_state_t   st;
        logic         dir;
        logic         obst_seen;
        logic [1:0]   sb_step;
        logic [DW-1:0] div;
        logic         tick;
        logic [13:0]  cnt;
        logic [13:0]  run_cnt;
        gop_in_t      prev;
        logic [6:0]   acl_sec;
        logic [6:0]   run_sec;
        gop_out_t     out;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
    } gop_st_t;

    gop_st_t  r_reg;
    gop_st_t  r_next;
    gop_in_t  di;
    logic [7:0] dsw;

    // -----------------------------------------
    // Helpers
    // -----------------------------------------
    // Seconds setting to tick count
    function automatic logic [13:0] ticks_of(input logic [6:0] s);
        ticks_of = 14'(s * SEC_TICKS);
    endfunction

    // Keep a written value inside its legal span
    function automatic logic [6:0] clamp(input logic [6:0] v,
                                         input logic [6:0] lo,
                                         input logic [6:0] hi);
        clamp = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // -----------------------------------------
    // Input conditioning
    // -----------------------------------------
    // Contacts and switches share one filter so all see equal delay
    gop_debounce #(
        .W   (18),
        .DBT (DB_TICKS)
    ) u_db (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (r_reg.tick),
        .din     ({dip_sw, ctl_in}),
        .dout    ({dsw, di})
    );

    logic hand, slave, open_lim, close_lim, cur_lim, cur_obst;
    logic e_open, e_close, e_single;
    logic [13:0] pre_ticks;

    // Hand decides which physical switch ends which travel
    assign hand      = dsw[SW_HAND];
    assign slave     = dsw[SW_SLAVE];
    assign open_lim  = hand ? di.close_end_switch_one
                            : di.open_end_switch_one;
    assign close_lim = hand ? di.open_end_switch_one
                            : di.close_end_switch_one;
    assign cur_lim   = r_reg.dir ? open_lim : close_lim;
    assign cur_obst  = r_reg.dir ? di.obst_open : di.obst_close;
    assign e_open    = di.open_cmd & ~r_reg.prev.open_cmd;
    assign e_close   = di.close_cmd & ~r_reg.prev.close_cmd;
    assign e_single  = di.single & ~r_reg.prev.single;

    // Warning lead covers the unlock wait, so the longer one wins
    assign pre_ticks = dsw[SW_PRE]  ? 14'(WARN_TICKS) :
                       dsw[SW_LOCK] ? 14'(LOCK_TICKS) : 14'h0;

    // -----------------------------------------
    // Next-state logic
    // -----------------------------------------
    always_comb begin
        logic go;
        logic go_dir;
        logic sb_open;
        logic sb_close;
        logic sb_stop;
        logic req_open;
        logic req_close;
        logic acl_ok;
        logic run;
        go        = 1'b0;
        req_open  = 1'b0;
        req_close = 1'b0;
        acl_ok    = 1'b0;
        run       = 1'b0;
        go_dir    = 1'b0;
        sb_open   = 1'b0;
        sb_close  = 1'b0;
        sb_stop   = 1'b0;
        r_next    = r_reg;
        r_next.prev = di;
        r_next.tick = 1'b0;

        // Time base
        if (r_reg.div == DIV_LAST) begin
            r_next.div  = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.div = r_reg.div + 1'b1;
        end

        // Single button is decided by the master only
        if (e_single && !slave) begin
            if (dsw[SW_SB]) begin
                sb_open  = (r_reg.sb_step == 2'h0);
                sb_close = (r_reg.sb_step == 2'h2);
                sb_stop  = r_reg.sb_step[0];
                r_next.sb_step = r_reg.sb_step + 2'h1;
            end else if (open_lim) begin
                sb_close = 1'b1;
            end else begin
                sb_open = 1'b1;
            end
        end
        req_open  = e_open | sb_open;
        req_close = (e_close | sb_close) & ~di.hold_open;

        // Auto close only from open with nothing asking otherwise
        acl_ok = dsw[SW_ACL] & ~slave & open_lim & ~r_reg.obst_seen
               & ~di.open_cmd & ~di.reverse & ~di.obst_open
               & ~di.obst_close & ~di.hold_open;

        case (r_reg.st)
            ST_IDLE: begin
                if (!acl_ok) begin
                    r_next.cnt = 14'h0;
                end else if (r_reg.cnt >= ticks_of(r_reg.acl_sec)) begin
                    go     = 1'b1;
                    go_dir = 1'b0;
                end else if (r_reg.tick) begin
                    r_next.cnt = r_reg.cnt + 14'h1;
                end
                if (req_open && !open_lim) begin
                    go     = 1'b1;
                    go_dir = 1'b1;
                end else if (req_close && !close_lim) begin
                    go     = 1'b1;
                    go_dir = 1'b0;
                end
            end
            ST_PRE: begin
                if (sb_stop) begin
                    r_next.st = ST_IDLE;
                end else if (r_reg.cnt >= pre_ticks) begin
                    r_next.st      = ST_RUN;
                    r_next.run_cnt = 14'h0;
                end else if (r_reg.tick) begin
                    r_next.cnt = r_reg.cnt + 14'h1;
                end
            end
            ST_RUN: begin
                if (r_reg.tick) begin
                    r_next.run_cnt = r_reg.run_cnt + 14'h1;
                end
                if (cur_lim) begin
                    r_next.st        = ST_IDLE;
                    r_next.obst_seen = 1'b0;
                end else if (cur_obst) begin
                    if (r_reg.obst_seen) begin
                        r_next.st = ST_LOCK;
                    end else begin
                        r_next.obst_seen = 1'b1;
                        r_next.st  = ST_BACK;
                        r_next.dir = ~r_reg.dir;
                        r_next.cnt = 14'h0;
                    end
                end else if (r_reg.run_cnt >= ticks_of(r_reg.run_sec)) begin
                    r_next.st = ST_LOCK;
                end else if (!r_reg.dir && (di.reverse || di.hold_open)) begin
                    // Turn round at once, no lead time while moving
                    r_next.dir     = 1'b1;
                    r_next.run_cnt = 14'h0;
                end else if (sb_stop) begin
                    r_next.st = ST_IDLE;
                end else if (req_open && !r_reg.dir) begin
                    go     = 1'b1;
                    go_dir = 1'b1;
                end else if (req_close && r_reg.dir) begin
                    go     = 1'b1;
                    go_dir = 1'b0;
                end
            end
            ST_BACK: begin
                // Short back-off after a first obstruction, then wait
                if (cur_lim || r_reg.cnt >= 14'(BACK_TICKS)) begin
                    r_next.st = ST_IDLE;
                end else if (r_reg.tick) begin
                    r_next.cnt = r_reg.cnt + 14'h1;
                end
            end
            ST_LOCK: begin
                r_next.st = ST_LOCK;
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        // A start passes the lead-time stage, or runs at once when no lead is set
        if (go) begin
            r_next.dir     = go_dir;
            r_next.cnt     = 14'h0;
            r_next.run_cnt = 14'h0;
            r_next.st      = (pre_ticks == 14'h0) ? ST_RUN : ST_PRE;
        end

        // Open stop loop beats everything but lockout
        if (!di.stop_ok && r_reg.st != ST_LOCK) begin
            r_next.st  = ST_IDLE;
            r_next.cnt = 14'h0;
        end

        // Outputs follow the next state so they leave a flop
        run = (r_next.st == ST_RUN) || (r_next.st == ST_BACK);
        r_next.out.motor_a  = run & (r_next.dir ^ hand);
        r_next.out.motor_b  = run & ~(r_next.dir ^ hand);
        r_next.out.brake    = ~run & ~dsw[SW_BRK];
        r_next.out.lock_rel = dsw[SW_LOCK]
                            & (run | (r_next.st == ST_PRE));
        r_next.out.warn     = run
                            | (dsw[SW_PRE] & (r_next.st == ST_PRE));
        r_next.out.alarm    = (r_next.st == ST_LOCK);
        r_next.out.lockout  = (r_next.st == ST_LOCK);
        r_next.out.slave    = slave;

        // APB: answer is prepared in setup, shown in access
        r_next.pready = 1'b0;
        if (psel && !penable) begin
            r_next.pready  = 1'b1;
            r_next.pslverr = ~((paddr == ADDR_CTRL) || (paddr == ADDR_STAT));
            r_next.prdata  = 32'h0;
            if (paddr == ADDR_CTRL) begin
                r_next.prdata[ACL_LSB +: 7] = r_reg.acl_sec;
                r_next.prdata[RUN_LSB +: 7] = r_reg.run_sec;
            end else if (paddr == ADDR_STAT) begin
                r_next.prdata[2:0]  = 3'(r_reg.st);
                r_next.prdata[3]    = r_reg.dir;
                r_next.prdata[4]    = r_reg.obst_seen;
                r_next.prdata[5]    = open_lim;
                r_next.prdata[6]    = close_lim;
                r_next.prdata[7]    = r_reg.out.lockout;
                r_next.prdata[15:8] = dsw;
            end
        end
        if (psel && penable && r_reg.pready && pwrite
            && paddr == ADDR_CTRL) begin
            r_next.acl_sec = clamp(pwdata[ACL_LSB +: 7], 7'h0, ACL_MAX);
            r_next.run_sec = clamp(pwdata[RUN_LSB +: 7], RUN_MIN, RUN_MAX);
        end
    end

    // -----------------------------------------
    // State register
    // -----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg         <= '0;
            r_reg.st      <= ST_IDLE;
            r_reg.acl_sec <= ACL_RST;
            r_reg.run_sec <= RUN_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata  = r_reg.prdata;
    assign pready  = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign ctl_out = r_reg.out;

    // -----------------------------------------
    // Checks
    // -----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_expired;
        r_reg.st == ST_RUN && !cur_lim && !cur_obst && di.stop_ok
        && r_reg.run_cnt >= ticks_of(r_reg.run_sec);
    endsequence
    sequence s_locked;
        r_reg.st == ST_LOCK ##1 ctl_out.alarm && ctl_out.lockout;
    endsequence
    a_stop_halts: assert property (
        (!di.stop_ok && r_reg.st != ST_LOCK)
        |=> r_reg.st == ST_IDLE && !ctl_out.motor_a && !ctl_out.motor_b)
        else $error("stop loop break did not halt motor");
    a_lock_sticks: assert property (
        r_reg.st == ST_LOCK |=> r_reg.st == ST_LOCK && ctl_out.alarm)
        else $error("lockout left without reset");
    a_warn_lead: assert property (
        (r_reg.st == ST_PRE && dsw[SW_PRE] && r_reg.cnt < WARN_TICKS)
        |=> r_reg.st != ST_RUN)
        else $error("motor started before warning lead");
    a_warn_quiet: assert property (
        (r_reg.st == ST_PRE && !dsw[SW_PRE] && $stable(dsw))
        |-> !ctl_out.warn)
        else $error("warning on before motion with lead off");
    // Motors leave the flop with the idle state; a fresh start may follow at once
    a_limit_stop: assert property (
        (r_reg.st == ST_RUN && cur_lim && di.stop_ok)
        |=> r_reg.st == ST_IDLE && !ctl_out.motor_a && !ctl_out.motor_b)
        else $error("limit switch did not stop travel");
    a_runtime_lock: assert property (s_expired |=> s_locked)
        else $error("max run expiry did not lock out");
    a_obst_repeat: assert property (
        (r_reg.st == ST_RUN && r_reg.obst_seen && cur_obst
         && !cur_lim && di.stop_ok) |=> s_locked)
        else $error("repeat obstruction did not lock out");
    a_obst_back: assert property (
        (r_reg.st == ST_RUN && !r_reg.obst_seen && cur_obst
         && !cur_lim && di.stop_ok)
        |=> r_reg.st == ST_BACK && r_reg.dir != $past(r_reg.dir)
            && r_reg.obst_seen)
        else $error("first obstruction did not back off");
endmodule
`default_nettype wire

// ===== rtl/gop_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module gop_debounce #(
    parameter int W   = 18,
    parameter int DBT = gop_pkg::DB_TICKS
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         tick,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import gop_pkg::*;
    localparam logic [1:0] DB_LAST = 2'(DBT - 1);
    typedef struct packed {
        logic [W-1:0]      s1;
        logic [W-1:0]      s2;
        logic [W-1:0]      q;
        logic [W-1:0][1:0] cnt;
    } gop_db_t;
    gop_db_t r_reg;
    gop_db_t r_next;

    // -----------------------------------------
    // Sync then require a stable level
    // -----------------------------------------
    // Each bit filters alone so one noisy contact cannot hold off another
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = din;
        r_next.s2 = r_reg.s1;
        for (int i = 0; i < W; i++) begin
            if (r_reg.s2[i] == r_reg.q[i]) begin
                r_next.cnt[i] = 2'h0;
            end else if (tick) begin
                if (r_reg.cnt[i] == DB_LAST) begin
                    r_next.q[i]   = r_reg.s2[i];
                    r_next.cnt[i] = 2'h0;
                end else begin
                    r_next.cnt[i] = r_reg.cnt[i] + 2'h1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign dout = r_reg.q;
endmodule
`default_nettype wire

// ===== rtl/gop_pkg.sv
`default_nettype none
package gop_pkg;
    // -----------------------------------------
    // Timing
    // -----------------------------------------
    localparam int CLK_HZ     = 20_000_000;
    localparam int TICK_MS    = 10;
    localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
    localparam int SEC_TICKS  = 1000 / TICK_MS;
    localparam int WARN_MS    = 2000;
    localparam int WARN_TICKS = WARN_MS / TICK_MS;
    localparam int LOCK_MS    = 1000;
    localparam int LOCK_TICKS = LOCK_MS / TICK_MS;
    localparam int BACK_MS    = 500;
    localparam int BACK_TICKS = BACK_MS / TICK_MS;
    localparam int DB_MS      = 20;
    localparam int DB_TICKS   = DB_MS / TICK_MS;
    // -----------------------------------------
    // Register map and fields
    // -----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam int         ACL_LSB   = 0;
    localparam int         RUN_LSB   = 8;
    localparam logic [6:0] ACL_RST   = 7'h1e;
    localparam logic [6:0] RUN_RST   = 7'h3c;
    localparam logic [6:0] ACL_MAX   = 7'h7c;
    localparam logic [6:0] RUN_MIN   = 7'h0f;
    localparam logic [6:0] RUN_MAX   = 7'h64;
    // -----------------------------------------
    // Configuration switch positions
    // -----------------------------------------
    localparam int SW_ACL   = 0;
    localparam int SW_PRE   = 1;
    localparam int SW_SB    = 2;
    localparam int SW_HAND  = 3;
    localparam int SW_LOCK  = 4;
    localparam int SW_BRK   = 5;
    localparam int SW_SLAVE = 7;
    // -----------------------------------------
    // Carriers
    // -----------------------------------------
    typedef struct packed {
        logic open_cmd;
        logic close_cmd;
        logic stop_ok;
        logic single;
        logic reverse;
        logic obst_open;
        logic obst_close;
        logic hold_open;
        logic open_end_switch_one;
        logic close_end_switch_one;
    } gop_in_t;
    typedef struct packed {
        logic motor_a;
        logic motor_b;
        logic brake;
        logic lock_rel;
        logic warn;
        logic alarm;
        logic lockout;
        logic slave;
    } gop_out_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_PRE, ST_RUN, ST_BACK, ST_LOCK
    } gop_state_t;
endpackage
`default_nettype wire

// ===== verification/gop_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gop_ctrl_tb;
    import gop_pkg::*;
    // ------------------------------------------
    // Setup
    // ------------------------------------------
    localparam int         T  = 4;
    localparam logic [7:0] MA = 8'h80;
    localparam logic [7:0] MB = 8'h40;
    localparam logic [7:0] MM = 8'hc0;
    localparam logic [7:0] BK = 8'h20;
    localparam logic [7:0] LR = 8'h10;
    localparam logic [7:0] WN = 8'h08;
    localparam logic [7:0] AL = 8'h04;
    localparam logic [7:0] LK = 8'h02;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, end_a, end_b, e, jam;
    logic [7:0]  paddr, dip_sw;
    logic [31:0] pwdata, prdata, rd;
    gop_in_t     cin, ctl_in;
    gop_out_t    ctl_out;
    int          err_count, checks_done, k;
    // Clock at 20 MHz
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // End switches come from the gate model, everything else from the bench
    assign ctl_in = {cin[9:2], end_a, end_b};
    gop_ctrl #(.TICK_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctl_in(ctl_in), .dip_sw(dip_sw),
        .ctl_out(ctl_out));
    gop_gate_model gate (.pclk(pclk), .motor_a(ctl_out.motor_a), .motor_b(ctl_out.motor_b),
        .jam(jam), .end_a(end_a), .end_b(end_b));
    // ------------------------------------------
    // Tasks
    // ------------------------------------------
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic co(input logic [7:0] m, input logic [7:0] v);
        chk({24'h0, ctl_out & m}, {24'h0, v});
    endtask
    // Request held until pready is sampled high; a spare edge keeps strobes clean
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            chk(32'h1, 32'h0);
            wrap_up;
        end
    endtask
    task automatic wait_out(input logic [7:0] m, input logic [7:0] v, input int lim);
        int n;
        for (n = 0; n < lim && (ctl_out & m) !== v; n++)
            @(posedge pclk);
        co(m, v);
        if (n == lim) wrap_up;
    endtask
    // Commands act on edges, so each press is held past debounce and released
    task automatic press(input int b);
        cin[b] <= 1'b1;
        repeat (40) @(posedge pclk);
        cin[b] <= 1'b0;
        repeat (40) @(posedge pclk);
    endtask
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dip_sw = 8'h02;
        cin = '0;
        cin.stop_ok = 1'b1;
        jam = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {17'h0, RUN_RST, 1'b0, ACL_RST});
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0000_7f7f);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {17'h0, RUN_MAX, 1'b0, ACL_MAX});
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_STAT, 32'hffff_ffff);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {17'h0, RUN_MIN, 1'b0, 7'h01});
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({rd[15:8], 5'h0, rd[2:0]}, {16'h0, 8'h02, 8'h00});
        $display("Registers done");
        press(9);
        co(MM | WN, WN);
        repeat (WARN_TICKS * T - 120) @(posedge pclk);
        co(MM | WN, WN);
        wait_out(MM, MA, 200);
        wait_out(MM | BK, BK, 1200);
        repeat (1200) @(posedge pclk);
        co(MM, 8'h00);
        cin.hold_open <= 1'b1;
        dip_sw <= 8'h03;
        repeat (1600) @(posedge pclk);
        press(8);
        co(MM, 8'h00);
        cin.hold_open <= 1'b0;
        wait_out(MM, MB, 1600);
        wait_out(MM, 8'h00, 2500);
        $display("Lead warning, limits and auto close done");
        dip_sw <= 8'h01;
        repeat (40) @(posedge pclk);
        press(9);
        co(MM | WN, MA | WN);
        repeat (400) @(posedge pclk);
        cin.obst_open <= 1'b1;
        wait_out(MM, MB, 60);
        cin.obst_open <= 1'b0;
        wait_out(MM, 8'h00, BACK_TICKS * T + 60);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[4]}, 32'h1);
        repeat (800) @(posedge pclk);
        co(MM, 8'h00);
        press(9);
        co(MM, MA);
        repeat (100) @(posedge pclk);
        cin.obst_open <= 1'b1;
        wait_out(MM | AL | LK, AL | LK, 60);
        cin.obst_open <= 1'b0;
        press(9);
        co(MM, 8'h00);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        co(AL | LK, 8'h00);
        $display("Open obstruction and lockout done");
        press(8);
        co(MM, MB);
        cin.reverse <= 1'b1;
        wait_out(MM, MA, 60);
        cin.reverse <= 1'b0;
        wait_out(MM, 8'h00, 2500);
        press(6);
        cin.obst_open <= 1'b1;
        repeat (60) @(posedge pclk);
        co(MM, MB);
        cin.obst_open <= 1'b0;
        repeat (400) @(posedge pclk);
        cin.obst_close <= 1'b1;
        wait_out(MM, MA, 60);
        cin.obst_close <= 1'b0;
        wait_out(MM, 8'h00, BACK_TICKS * T + 60);
        $display("Reverse and close obstruction done");
        dip_sw <= 8'h00;
        repeat (40) @(posedge pclk);
        press(6);
        co(MM, MA);
        cin.stop_ok <= 1'b0;
        wait_out(MM, 8'h00, 60);
        press(9);
        co(MM, 8'h00);
        cin.stop_ok <= 1'b1;
        dip_sw <= 8'h18;
        repeat (40) @(posedge pclk);
        press(9);
        co(MM | LR, LR);
        repeat (LOCK_TICKS * T - 120) @(posedge pclk);
        co(MM, 8'h00);
        wait_out(MM, MB, 200);
        cin.stop_ok <= 1'b0;
        wait_out(MM, 8'h00, 60);
        cin.stop_ok <= 1'b1;
        dip_sw <= 8'h24;
        repeat (40) @(posedge pclk);
        for (k = 0; k < 4; k++) begin
            press(6);
            co(MM, (k == 0) ? MA : (k == 2) ? MB : 8'h00);
        end
        co(BK, 8'h00);
        dip_sw <= 8'h80;
        repeat (40) @(posedge pclk);
        co(8'h01, 8'h01);
        $display("Stop loop, hand, lock delay, single button done");
        // A jammed leaf never meets a limit, so only the run timer ends the travel
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        jam <= 1'b1;
        press(9);
        co(MM, MA);
        wait_out(MM | AL | LK, AL | LK, 6200);
        $display("Run timer lockout done");
        wrap_up;
    end
endmodule
`default_nettype wire

// ===== verification/gop_gate_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------
// Sliding gate with one end switch per end
// ------------------------------------------
module gop_gate_model #(
    parameter int TRAVEL = 2000,
    parameter int START  = 1000
) (
    input  wire logic pclk,
    input  wire logic motor_a,
    input  wire logic motor_b,
    input  wire logic jam,
    output logic      end_a,
    output logic      end_b
);
    int pos = START;
    // The gate keeps its place over a controller reset, as a real leaf does
    always @(posedge pclk) begin
        // A jammed leaf stays put whatever the motor does
        if (!jam && motor_a && !motor_b && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (!jam && motor_b && !motor_a && pos > 0) begin
            pos <= pos - 1;
        end
    end
    // End switches close only at the physical travel ends
    assign end_a = (pos >= TRAVEL);
    assign end_b = (pos <= 0);
endmodule
`default_nettype wire
